// ===== src/sfz_pkg.sv
// constants, types and shared layouts for the sanitize freeze and status logic
// Behaviour
// - a successful freeze-lock command moves the sanitize machine into the frozen state
// - while frozen, every sanitize command except the status query is aborted
// - only power-on reset or hardware reset returns the frozen machine to idle
// - operation commands abort once any freeze lock succeeded since power-on reset
// - abort an overwrite with policy bit set when failed under a policy-clear command
// - error reason code in sector number: none, unsuccessful, bad feature, frozen
// - sector count bit 15 is one on reaching succeeded, zero on entering operation
// - the completed-without-error flag survives power-on reset in nonvolatile storage
// - sector count bit 14 reports a sanitize operation in progress
// - sector count bit 13 reports the frozen state
// - 16-bit progress over 65536: high byte cylinder low, low byte sector number
// - progress reads all ones with no operation in process, unless an abort or reason code takes the sector number byte
package sfz_pkg;
	// command and feature codes
	localparam logic [7:0] SFZ_OPC_SANITIZE = 8'hB4;
	localparam logic [15:0] SFZ_FEAT_STATUS = 16'h0000;
	localparam logic [15:0] SFZ_FEAT_OVERWRITE = 16'h0014;
	localparam logic [15:0] SFZ_FEAT_FREEZE = 16'h0020;
	// error reason codes
	localparam logic [7:0] SFZ_RSN_NONE = 8'h00;
	localparam logic [7:0] SFZ_RSN_UNSUCCESSFUL = 8'h01;
	localparam logic [7:0] SFZ_RSN_BAD_FEATURE = 8'h02;
	localparam logic [7:0] SFZ_RSN_FROZEN = 8'h03;
	// command sector count fields
	localparam int SFZ_SC_INVERT = 7;
	localparam int SFZ_SC_FAIL_POLICY = 4;
	localparam int SFZ_SC_CLEAR_FAILED = 0;
	localparam int SFZ_SC_COUNT_HI = 3;
	// returned sector count fields
	localparam int SFZ_RC_CWE = 15;
	localparam int SFZ_RC_IN_PROGRESS = 14;
	localparam int SFZ_RC_FROZEN = 13;
	// error and status register bits
	localparam int SFZ_ERR_ABORT = 2;
	localparam int SFZ_ST_BUSY = 7;
	localparam int SFZ_ST_READY = 6;
	localparam int SFZ_ST_SEEK_DONE = 4;
	localparam int SFZ_ST_ERROR = 0;
	// reset and idle values
	localparam logic [7:0] SFZ_STATUS_RESET = 8'h50;
	localparam logic [7:0] SFZ_ZERO8 = 8'h00;
	localparam logic [15:0] SFZ_ZERO16 = 16'h0000;
	localparam logic [15:0] SFZ_PROG_IDLE = 16'hFFFF;
	// sanitize state machine
	typedef enum logic [4:0] {
		sanitize_idle_state = 5'h01,
		sanitize_frozen_state = 5'h02,
		sanitize_running_state = 5'h04,
		sanitize_failed_state = 5'h08,
		sanitize_succeeded_state = 5'h10
	} sfz_san_t;
	// command handling machine
	typedef enum logic [1:0] {
		SFZ_CMD_WAIT = 2'h1,
		SFZ_CMD_EXEC = 2'h2
	} sfz_cmd_t;
endpackage : sfz_pkg

// ===== src/sfz_nv_flag.sv
// completed-without-error flag mirrored into external nonvolatile storage
`timescale 1ns/100ps
`default_nettype none
module sfz_nv_flag
	import sfz_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// update requests
	input wire logic set_pulse,
	input wire logic clr_pulse,
	// storage side
	input wire logic nv_restore,
	output logic nv_store_en,
	output logic nv_store_data,
	// current value
	output logic flag
);
	logic flag_ff, nxt_flag;
	logic loaded_ff, nxt_loaded;
	logic st_en_ff, nxt_st_en;

	// stored value is taken back once after reset release, since reset may not load a port
	always_comb begin
		nxt_loaded = 1'b1;
		nxt_flag = flag_ff;
		nxt_st_en = 1'b0;
		if (!loaded_ff) begin
			nxt_flag = nv_restore;
		end else if (set_pulse) begin
			nxt_flag = 1'b1;
			nxt_st_en = 1'b1;
		end else if (clr_pulse) begin
			nxt_flag = 1'b0;
			nxt_st_en = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flag_ff <= 1'b0;
			loaded_ff <= 1'b0;
			st_en_ff <= 1'b0;
		end else begin
			flag_ff <= nxt_flag;
			loaded_ff <= nxt_loaded;
			st_en_ff <= nxt_st_en;
		end
	end

	assign flag = flag_ff;
	assign nv_store_en = st_en_ff;
	assign nv_store_data = flag_ff;
endmodule : sfz_nv_flag
`default_nettype wire

// ===== src/sfz_progress.sv
// progress numerator tracker for the running sanitize operation
`timescale 1ns/100ps
`default_nettype none
module sfz_progress
	import sfz_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// operation state
	input wire logic running,
	input wire logic [15:0] media_progress,
	// reported value
	output logic [15:0] progress
);
	logic [15:0] prog_ff, nxt_prog;

	// all ones outside an operation, engine value during one
	always_comb begin
		nxt_prog = SFZ_PROG_IDLE;
		if (running) begin
			nxt_prog = media_progress;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prog_ff <= SFZ_PROG_IDLE;
		end else begin
			prog_ff <= nxt_prog;
		end
	end

	assign progress = prog_ff;
endmodule : sfz_progress
`default_nettype wire

// ===== src/sfz_sanitize_ctrl.sv
// sanitize command interpreter: freeze lock, aborts, status and progress returns
`timescale 1ns/100ps
`default_nettype none
module sfz_sanitize_ctrl
	import sfz_pkg::*;
(
	// clock and power-on reset
	input wire logic mclk,
	input wire logic rst_n,
	// hardware reset pin, asynchronous
	input wire logic hw_reset_pin,
	// command block written by the host
	input wire logic tf_cmd_wr,
	input wire logic [7:0] tf_command,
	input wire logic [15:0] tf_feature,
	input wire logic [7:0] tf_sector_count,
	input wire logic [31:0] tf_pattern,
	// media engine
	input wire logic media_done,
	input wire logic media_fail,
	input wire logic [15:0] media_progress,
	output logic op_start,
	output logic op_invert,
	output logic [3:0] op_count,
	output logic [31:0] op_pattern,
	// nonvolatile storage
	input wire logic nv_restore,
	output logic nv_store_en,
	output logic nv_store_data,
	// returned command block
	output logic [7:0] command_error_flags,
	output logic [7:0] device_condition_flags,
	output logic [15:0] rd_sector_count,
	output logic [7:0] rd_sector_number,
	output logic [7:0] rd_cylinder_low,
	output logic cmd_done
);
	sfz_san_t san_ff, nxt_san;
	sfz_cmd_t cmd_ff, nxt_cmd;
	logic [15:0] feat_ff, nxt_feat;
	logic [7:0] scnt_ff, nxt_scnt;
	logic [31:0] pat_ff, nxt_pat;
	logic freeze_por_ff, nxt_freeze_por;
	logic fail_policy_ff, nxt_fail_policy;
	logic [7:0] err_ff, nxt_err;
	logic [7:0] stat_ff, nxt_stat;
	logic [15:0] rsc_ff, nxt_rsc;
	logic [7:0] rsn_ff, nxt_rsn;
	logic [7:0] rcl_ff, nxt_rcl;
	logic done_ff, nxt_done;
	logic start_ff, nxt_start;
	logic invert_ff, nxt_invert;
	logic [3:0] count_ff, nxt_count;
	logic [31:0] opat_ff, nxt_opat;
	logic hwr_meta_ff, hwr_sync_ff;
	logic nxt_hwr_meta, nxt_hwr_sync;
	logic cmd_take;
	logic [15:0] prog_sel;
	logic cwe_set, cwe_clr;
	logic cwe_flag;
	logic [15:0] progress;
	logic abort;
	logic [7:0] reason;

	// completed-without-error flag kept outside power domain
	// restored once after power-on reset, so bit 15 survives it
	sfz_nv_flag u_nv (
		.mclk(mclk),
		.rst_n(rst_n),
		.set_pulse(cwe_set),
		.clr_pulse(cwe_clr),
		.nv_restore(nv_restore),
		.nv_store_en(nv_store_en),
		.nv_store_data(nv_store_data),
		.flag(cwe_flag)
	);

	// progress numerator, forced to all ones when idle
	sfz_progress u_prog (
		.mclk(mclk),
		.rst_n(rst_n),
		.running(san_ff == sanitize_running_state),
		.media_progress(media_progress),
		.progress(progress)
	);

	// hardware reset pin passes two flops before use; only the second one is read
	always_comb begin
		nxt_hwr_meta = hw_reset_pin;
		nxt_hwr_sync = hwr_meta_ff;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hwr_meta_ff <= 1'b0;
			hwr_sync_ff <= 1'b0;
		end else begin
			hwr_meta_ff <= nxt_hwr_meta;
			hwr_sync_ff <= nxt_hwr_sync;
		end
	end

	// a command is only taken while idle; a write during busy falls away
	assign cmd_take = tf_cmd_wr && tf_command == SFZ_OPC_SANITIZE && cmd_ff == SFZ_CMD_WAIT;

	// command decision and sanitize state transitions
	always_comb begin
		nxt_san = san_ff;
		nxt_cmd = cmd_ff;
		nxt_feat = feat_ff;
		nxt_scnt = scnt_ff;
		nxt_pat = pat_ff;
		nxt_freeze_por = freeze_por_ff;
		nxt_fail_policy = fail_policy_ff;
		nxt_err = err_ff;
		nxt_stat = stat_ff;
		nxt_rsc = rsc_ff;
		nxt_rsn = rsn_ff;
		nxt_rcl = rcl_ff;
		nxt_done = 1'b0;
		nxt_start = 1'b0;
		nxt_invert = invert_ff;
		nxt_count = count_ff;
		nxt_opat = opat_ff;
		cwe_set = 1'b0;
		cwe_clr = 1'b0;
		abort = 1'b0;
		reason = SFZ_RSN_NONE;
		prog_sel = SFZ_PROG_IDLE;
		// background operation finishes on its own
		if (san_ff == sanitize_running_state) begin
			// a failure report outranks a done report in the same cycle
			if (media_fail) begin
				nxt_san = sanitize_failed_state;
			end else if (media_done) begin
				nxt_san = sanitize_succeeded_state;
				cwe_set = 1'b1;
			end
		end
		// hardware reset only unlocks a frozen machine
		// the freeze memory is left alone, so operation commands still abort
		if (hwr_sync_ff && san_ff == sanitize_frozen_state) begin
			nxt_san = sanitize_idle_state;
		end
		case (cmd_ff)
			SFZ_CMD_WAIT: begin
				// commands outside the sanitize opcode belong to other logic
				if (cmd_take) begin
					// fields latched so the host may move them after the strobe
					nxt_feat = tf_feature;
					nxt_scnt = tf_sector_count;
					nxt_pat = tf_pattern;
					nxt_cmd = SFZ_CMD_EXEC;
					nxt_stat[SFZ_ST_BUSY] = 1'b1;
				end
			end
			SFZ_CMD_EXEC: begin
				nxt_cmd = SFZ_CMD_WAIT;
				nxt_done = 1'b1;
				case (feat_ff)
					SFZ_FEAT_STATUS: begin
						// status query runs in every state, frozen included
						// clearing a failure honours the exit policy of the failed run
						if (scnt_ff[SFZ_SC_CLEAR_FAILED] && san_ff == sanitize_failed_state) begin
							if (fail_policy_ff) begin
								nxt_san = sanitize_idle_state;
							end else begin
								abort = 1'b1;
							end
						end
						if (san_ff == sanitize_failed_state) begin
							reason = SFZ_RSN_UNSUCCESSFUL;
						end
					end
					SFZ_FEAT_FREEZE: begin
						if (san_ff == sanitize_frozen_state) begin
							abort = 1'b1;
							reason = SFZ_RSN_FROZEN;
						end else if (san_ff == sanitize_running_state) begin
							// freezing mid-run would strand the media engine
							abort = 1'b1;
						end else begin
							nxt_san = sanitize_frozen_state;
							nxt_freeze_por = 1'b1;
						end
					end
					SFZ_FEAT_OVERWRITE: begin
						// frozen is checked first so the host sees the frozen reason
						if (san_ff == sanitize_frozen_state) begin
							abort = 1'b1;
							reason = SFZ_RSN_FROZEN;
						end else if (freeze_por_ff) begin
							// the lock memory outlives a hardware reset
							abort = 1'b1;
						end else if (san_ff == sanitize_running_state) begin
							abort = 1'b1;
						end else if (san_ff == sanitize_failed_state && !fail_policy_ff
							&& scnt_ff[SFZ_SC_FAIL_POLICY]) begin
							abort = 1'b1;
							reason = SFZ_RSN_UNSUCCESSFUL;
						end else begin
							// operation starts, media engine takes over
							nxt_san = sanitize_running_state;
							nxt_fail_policy = scnt_ff[SFZ_SC_FAIL_POLICY];
							nxt_start = 1'b1;
							nxt_invert = scnt_ff[SFZ_SC_INVERT];
							nxt_count = scnt_ff[SFZ_SC_COUNT_HI:0];
							nxt_opat = pat_ff;
							cwe_clr = 1'b1;
						end
					end
					default: begin
						// unsupported features, crypto scramble among them
						abort = 1'b1;
						reason = SFZ_RSN_BAD_FEATURE;
						if (san_ff == sanitize_frozen_state) begin
							reason = SFZ_RSN_FROZEN;
						end
					end
				endcase
				// returned registers; bits built from the state at completion
				nxt_rsc = SFZ_ZERO16;
				// bit 15 shows the flag as it stands after this cycle
				nxt_rsc[SFZ_RC_CWE] = cwe_set | (cwe_flag & ~cwe_clr);
				nxt_rsc[SFZ_RC_IN_PROGRESS] = (nxt_san == sanitize_running_state);
				nxt_rsc[SFZ_RC_FROZEN] = (nxt_san == sanitize_frozen_state);
				// the tracker lags a cycle, so a run ending now must not leak its numerator
				prog_sel = progress;
				if (nxt_san != sanitize_running_state) begin
					prog_sel = SFZ_PROG_IDLE;
				end
				nxt_rcl = prog_sel[15:8];
				nxt_rsn = prog_sel[7:0];
				if (abort || reason != SFZ_RSN_NONE) begin
					nxt_rsn = reason;
				end
				// error and status rebuilt from scratch for every completion
				nxt_err = SFZ_ZERO8;
				nxt_err[SFZ_ERR_ABORT] = abort;
				nxt_stat = SFZ_STATUS_RESET;
				nxt_stat[SFZ_ST_BUSY] = 1'b0;
				nxt_stat[SFZ_ST_ERROR] = abort;
			end
			default: begin
				nxt_cmd = SFZ_CMD_WAIT;
			end
		endcase
	end

	// all control state returns to idle on power-on reset
	// the completed flag is not here; it lives in the nonvolatile mirror
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			san_ff <= sanitize_idle_state;
			cmd_ff <= SFZ_CMD_WAIT;
			feat_ff <= SFZ_ZERO16;
			scnt_ff <= SFZ_ZERO8;
			pat_ff <= 32'h00000000;
			freeze_por_ff <= 1'b0;
			fail_policy_ff <= 1'b0;
			err_ff <= SFZ_ZERO8;
			stat_ff <= SFZ_STATUS_RESET;
			rsc_ff <= SFZ_ZERO16;
			rsn_ff <= SFZ_ZERO8;
			rcl_ff <= SFZ_ZERO8;
			done_ff <= 1'b0;
			start_ff <= 1'b0;
			invert_ff <= 1'b0;
			count_ff <= 4'h0;
			opat_ff <= 32'h00000000;
		end else begin
			san_ff <= nxt_san;
			cmd_ff <= nxt_cmd;
			feat_ff <= nxt_feat;
			scnt_ff <= nxt_scnt;
			pat_ff <= nxt_pat;
			freeze_por_ff <= nxt_freeze_por;
			fail_policy_ff <= nxt_fail_policy;
			err_ff <= nxt_err;
			stat_ff <= nxt_stat;
			rsc_ff <= nxt_rsc;
			rsn_ff <= nxt_rsn;
			rcl_ff <= nxt_rcl;
			done_ff <= nxt_done;
			start_ff <= nxt_start;
			invert_ff <= nxt_invert;
			count_ff <= nxt_count;
			opat_ff <= nxt_opat;
		end
	end

	// every output straight from a flop
	// host reads other than the busy bit hold until the next completion rewrites them
	assign command_error_flags = err_ff;
	assign device_condition_flags = stat_ff;
	assign rd_sector_count = rsc_ff;
	assign rd_sector_number = rsn_ff;
	assign rd_cylinder_low = rcl_ff;
	assign cmd_done = done_ff;
	assign op_start = start_ff;
	assign op_invert = invert_ff;
	assign op_count = count_ff;
	assign op_pattern = opat_ff;
endmodule : sfz_sanitize_ctrl
`default_nettype wire

// ===== sim/sfz_ctrl_sva.sv
// assertions on the sanitize interpreter ports
`timescale 1ns/100ps
`default_nettype none
module sfz_ctrl_sva
	import sfz_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// command in
	input wire logic hw_reset_pin,
	input wire logic tf_cmd_wr,
	input wire logic [7:0] tf_command,
	input wire logic [15:0] tf_feature,
	// returns
	input wire logic op_start,
	input wire logic [7:0] command_error_flags,
	input wire logic [7:0] device_condition_flags,
	input wire logic [15:0] rd_sector_count,
	input wire logic [7:0] rd_sector_number,
	input wire logic [7:0] rd_cylinder_low,
	input wire logic cmd_done
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic take, ab, froze_ff, nxt_froze;
	logic thaw_ff, nxt_thaw;
	assign take = tf_cmd_wr && tf_command == SFZ_OPC_SANITIZE && !device_condition_flags[SFZ_ST_BUSY];
	assign ab = command_error_flags[SFZ_ERR_ABORT];
	// freeze seen since power-on; a hardware reset must not clear it
	always_comb begin
		nxt_froze = froze_ff | (cmd_done & ~ab & rd_sector_count[SFZ_RC_FROZEN]);
		// a hardware reset thaws the machine until the next successful freeze
		nxt_thaw = (thaw_ff | hw_reset_pin) & ~(cmd_done & ~ab & rd_sector_count[SFZ_RC_FROZEN]);
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			froze_ff <= 1'b0;
			thaw_ff <= 1'b0;
		end else begin
			froze_ff <= nxt_froze;
			thaw_ff <= nxt_thaw;
		end
	end
	sequence taken_s;
		take;
	endsequence
	sequence answer_s;
		device_condition_flags[SFZ_ST_BUSY] ##1 (cmd_done && !device_condition_flags[SFZ_ST_BUSY]);
	endsequence
	busy_answer_a: assert property (taken_s |=> answer_s)
		else $error("command not answered in two cycles");
	frozen_abort_a: assert property (take && tf_feature != SFZ_FEAT_STATUS && nxt_froze
		&& !(tf_feature == SFZ_FEAT_FREEZE && nxt_thaw) |-> ##2 ab)
		else $error("command not aborted after freeze");
	freeze_ok_a: assert property (take && tf_feature == SFZ_FEAT_FREEZE && !nxt_froze
		&& !rd_sector_count[SFZ_RC_IN_PROGRESS] |-> ##2 rd_sector_count[SFZ_RC_FROZEN] && !ab)
		else $error("freeze did not take");
	abort_flags_a: assert property (cmd_done && ab |-> device_condition_flags == 8'h51)
		else $error("abort status wrong");
	idle_prog_a: assert property (cmd_done && !ab && !rd_sector_count[SFZ_RC_IN_PROGRESS]
		|-> rd_cylinder_low == 8'hFF)
		else $error("idle progress not all ones");
	start_flags_a: assert property (op_start |-> cmd_done && rd_sector_count[15:13] == 3'b010)
		else $error("start flags wrong");
	frozen_bit_a: assert property (cmd_done && rd_sector_count[SFZ_RC_FROZEN] |-> nxt_froze)
		else $error("frozen bit without freeze");
	reason_a: assert property (cmd_done && ab |-> rd_sector_number < 8'h04)
		else $error("reserved reason code");
endmodule : sfz_ctrl_sva
`default_nettype wire

// ===== sim/sfz_media_model.sv
// media engine and nonvolatile cell behind the interpreter
`timescale 1ns/100ps
`default_nettype none
module sfz_media_model
	import sfz_pkg::*;
#(
	parameter int RUN_CYC = 40,
	parameter logic [15:0] MID_PROG = 16'h1234
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// media run
	input wire logic op_start,
	input wire logic fail_sel,
	output logic media_done,
	output logic media_fail,
	output logic [15:0] media_progress,
	// nonvolatile cell
	input wire logic nv_store_en,
	input wire logic nv_store_data,
	output logic nv_restore
);
	int cnt_ff;
	logic [15:0] tick_ff = 16'h0000;
	logic cell_ff = 1'b0;
	// run length; reports once as it reaches one
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 0;
		end else if (op_start) begin
			cnt_ff <= RUN_CYC;
		end else if (cnt_ff > 0) begin
			cnt_ff <= cnt_ff - 1;
		end
	end
	// cell ignores reset, it stands for storage that outlives power
	always @(posedge mclk) begin
		tick_ff <= tick_ff + 16'h0001;
		if (nv_store_en === 1'b1) begin
			cell_ff <= nv_store_data;
		end
	end
	assign nv_restore = cell_ff;
	assign media_done = cnt_ff == 1 && !fail_sel;
	assign media_fail = cnt_ff == 1 && fail_sel;
	// idle value wanders so a stale capture shows
	assign media_progress = cnt_ff > 0 ? MID_PROG : tick_ff;
endmodule : sfz_media_model
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the sanitize interpreter
`timescale 1ns/100ps
`default_nettype none
module tb
	import sfz_pkg::*;
;
	typedef struct packed {
		logic [15:0] feat;
		logic [7:0] sc;
		logic [7:0] err;
		logic [15:0] rsc;
		logic [7:0] sn;
	} sfz_row_t;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic hw_reset_pin = 1'b0;
	logic tf_cmd_wr = 1'b0;
	logic fail_sel = 1'b0;
	logic [7:0] tf_command = SFZ_OPC_SANITIZE;
	logic [15:0] tf_feature = SFZ_FEAT_STATUS;
	logic [7:0] tf_sector_count = 8'h00;
	logic media_done, media_fail, op_start, nv_restore, nv_store_en, nv_store_data, cmd_done;
	logic [15:0] media_progress, rd_sector_count;
	logic [7:0] command_error_flags, device_condition_flags, rd_sector_number, rd_cylinder_low;
	logic op_invert;
	logic [3:0] op_count;
	logic [31:0] op_pattern;
	int n_errors = 0;
	int checks = 0;
	int n_done = 0;
	int d0;
	sfz_row_t rows [9] = '{
		'{SFZ_FEAT_STATUS, 8'h00, 8'h00, 16'h0000, 8'hFF},
		'{16'h0011, 8'h00, 8'h04, 16'h0000, 8'h02},
		'{SFZ_FEAT_OVERWRITE, 8'h03, 8'h00, 16'h4000, 8'hFF},
		'{SFZ_FEAT_STATUS, 8'h00, 8'h00, 16'h8000, 8'hFF},
		'{SFZ_FEAT_FREEZE, 8'h00, 8'h00, 16'hA000, 8'hFF},
		'{SFZ_FEAT_STATUS, 8'h00, 8'h00, 16'hA000, 8'hFF},
		'{SFZ_FEAT_OVERWRITE, 8'h03, 8'h04, 16'hA000, 8'h03},
		'{SFZ_FEAT_FREEZE, 8'h00, 8'h04, 16'hA000, 8'h03},
		'{16'h0011, 8'h00, 8'h04, 16'hA000, 8'h03}
	};
	sfz_sanitize_ctrl DUT (
		.mclk, .rst_n, .hw_reset_pin, .tf_cmd_wr, .tf_command, .tf_feature, .tf_sector_count,
		.tf_pattern(32'hC3A55A3C), .media_done, .media_fail, .media_progress, .op_start,
		.op_invert, .op_count, .op_pattern, .nv_restore, .nv_store_en, .nv_store_data,
		.command_error_flags, .device_condition_flags, .rd_sector_count, .rd_sector_number,
		.rd_cylinder_low, .cmd_done
	);
	sfz_media_model #(.RUN_CYC(40), .MID_PROG(16'h1234)) u_media (
		.mclk, .rst_n, .op_start, .fail_sel, .media_done, .media_fail, .media_progress,
		.nv_store_en, .nv_store_data, .nv_restore
	);
	always #2 mclk = ~mclk;
	// completions counted for the refusal check
	always @(posedge mclk) begin
		if (cmd_done === 1'b1) begin
			n_done++;
		end
	end
	task automatic report_and_stop();
		if (n_errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one command, bounded wait for completion, then the returned block
	task automatic step(input sfz_row_t r);
		int i;
		@(negedge mclk);
		tf_feature = r.feat;
		tf_sector_count = r.sc;
		tf_cmd_wr = 1'b1;
		@(negedge mclk);
		tf_cmd_wr = 1'b0;
		for (i = 0; i < 8 && cmd_done !== 1'b1; i++) begin
			@(negedge mclk);
		end
		if (i == 8) begin
			chk("cmd_done", 16'h0001, 16'h0000);
			report_and_stop();
		end
		chk("error", 16'(r.err), 16'(command_error_flags));
		chk("status", r.err != 8'h00 ? 16'h0051 : 16'h0050, 16'(device_condition_flags));
		chk("sector_count", r.rsc, rd_sector_count);
		chk("sector_number", 16'(r.sn), 16'(rd_sector_number));
	endtask : step
	initial begin
		repeat (20) @(negedge mclk);
		rst_n = 1'b1;
		for (int k = 0; k < 9; k++) begin
			step(rows[k]);
			repeat (48) @(negedge mclk);
		end
		// write during busy is dropped, foreign opcode never answered
		d0 = n_done;
		@(negedge mclk);
		tf_cmd_wr = 1'b1;
		repeat (2) @(negedge mclk);
		tf_command = 8'hEC;
		@(negedge mclk);
		tf_cmd_wr = 1'b0;
		tf_command = SFZ_OPC_SANITIZE;
		repeat (6) @(negedge mclk);
		chk("done_count", 16'h0001, 16'(n_done - d0));
		// hardware reset unfreezes, the freeze stays remembered
		hw_reset_pin = 1'b1;
		repeat (3) @(negedge mclk);
		hw_reset_pin = 1'b0;
		repeat (6) @(negedge mclk);
		step('{SFZ_FEAT_STATUS, 8'h00, 8'h00, 16'h8000, 8'hFF});
		step('{SFZ_FEAT_OVERWRITE, 8'h03, 8'h04, 16'h8000, 8'h00});
		// power-on reset clears, completed flag comes back from storage
		rst_n = 1'b0;
		repeat (20) @(negedge mclk);
		chk("status", 16'h0050, 16'(device_condition_flags));
		chk("error", 16'h0000, 16'(command_error_flags));
		rst_n = 1'b1;
		step('{SFZ_FEAT_STATUS, 8'h00, 8'h00, 16'h8000, 8'hFF});
		// failing run under policy zero, then a policy-one retry
		fail_sel = 1'b1;
		step('{SFZ_FEAT_OVERWRITE, 8'h83, 8'h00, 16'h4000, 8'hFF});
		chk("op_control", 16'h0013, {11'h000, op_invert, op_count});
		chk("pattern_hi", 16'hC3A5, op_pattern[31:16]);
		chk("pattern_lo", 16'h5A3C, op_pattern[15:0]);
		repeat (10) @(negedge mclk);
		step('{SFZ_FEAT_STATUS, 8'h00, 8'h00, 16'h4000, 8'h34});
		chk("cylinder_low", 16'h0012, 16'(rd_cylinder_low));
		repeat (48) @(negedge mclk);
		step('{SFZ_FEAT_STATUS, 8'h00, 8'h00, 16'h0000, 8'h01});
		step('{SFZ_FEAT_STATUS, 8'h01, 8'h04, 16'h0000, 8'h01});
		step('{SFZ_FEAT_OVERWRITE, 8'h13, 8'h04, 16'h0000, 8'h01});
		// power-on reset again, then a policy-one failure cleared by the status query
		rst_n = 1'b0;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		step('{SFZ_FEAT_OVERWRITE, 8'h13, 8'h00, 16'h4000, 8'hFF});
		repeat (48) @(negedge mclk);
		step('{SFZ_FEAT_STATUS, 8'h01, 8'h00, 16'h0000, 8'h01});
		step('{SFZ_FEAT_STATUS, 8'h00, 8'h00, 16'h0000, 8'hFF});
		report_and_stop();
	end
endmodule : tb
bind sfz_sanitize_ctrl sfz_ctrl_sva u_sva (
	.mclk, .rst_n, .hw_reset_pin, .tf_cmd_wr, .tf_command, .tf_feature, .op_start, .command_error_flags,
	.device_condition_flags, .rd_sector_count, .rd_sector_number, .rd_cylinder_low, .cmd_done
);
`default_nettype wire
